// ==== rtl/azc_ctrl.sv ====
// auto-zero trim controller driving a converter through a parallel port adapter
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module azc_ctrl
   import azc_pkg::*;
(
   // clocking
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // own register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // port adapter i/o bus
   output azc_iobus_t ioBus,
   input wire logic [7:0] ioRdData,
   input wire logic intrReq_n
);

   // *****************************************
   // state
   // *****************************************
   azc_state_t state;
   logic zeroing;
   logic cmdZero;
   logic cmdConv;
   logic zeroDone;
   logic convDone;
   logic [7:0] trimCode;
   logic [7:0] trimPtr;
   logic [7:0] swState;
   logic [7:0] result;
   logic [3:0] rdCnt;
   logic [3:0] convCount;
   logic [7:0] dataStable;
   logic intrStable;
   logic intrPrev;
   logic intrPend;
   logic intrEvent;
   logic [7:0] next_trimCode;
   logic [7:0] next_trimPtr;
   logic takeZero;
   logic takeConv;
   logic readLast;

   // *****************************************
   // pin synchronisers
   // *****************************************
   azc_sync #(.W(8), .INIT(8'h00)) uDataSync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .pinIn(ioRdData),
      .stable(dataStable)
   );

   azc_sync #(.W(1), .INIT(1'b1)) uIntrSync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .pinIn(intrReq_n),
      .stable(intrStable)
   );

   // completion seen as the filtered request falling low
   assign intrEvent = intrPrev && !intrStable;
   assign takeZero = (state == S_IDLE) && cmdZero;
   assign takeConv = (state == S_IDLE) && !cmdZero && cmdConv;
   assign readLast = (state == S_READ) && (rdCnt == RD_CYCLES - 4'h1);

   // pending completion, cleared when a new conversion starts; a new edge wins
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         intrPrev <= 1'b1;
         intrPend <= 1'b0;
      end else if (ce) begin
         intrPrev <= intrStable;
         if (intrEvent) begin
            intrPend <= 1'b1;
         end else if (state == S_START) begin
            intrPend <= 1'b0;
         end
      end
   end

   // *****************************************
   // sequencer
   // *****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= S_IDLE;
         zeroing <= 1'b0;
      end else if (ce) begin
         unique case (state)
            S_IDLE: begin
               if (takeZero) begin
                  state <= S_CFG;
                  zeroing <= 1'b1;
               end else if (takeConv) begin
                  state <= S_START;
                  zeroing <= 1'b0;
               end
            end
            S_CFG: state <= S_SW;
            S_SW: state <= S_TRIM;
            S_TRIM: state <= S_START;
            S_START: state <= S_WAIT;
            S_WAIT: begin
               if (intrPend) begin
                  state <= S_READ;
               end
            end
            S_READ: begin
               if (readLast) begin
                  state <= zeroing ? S_EVAL : S_IDLE;
               end
            end
            S_EVAL: state <= (next_trimPtr == 8'h00) ? S_FINISH : S_TRIM;
            S_FINISH: begin
               state <= S_IDLE;
               zeroing <= 1'b0;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // read strobe length counter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdCnt <= 4'h0;
      end else if (ce) begin
         if (state == S_READ) begin
            rdCnt <= rdCnt + 4'h1;
         end else begin
            rdCnt <= 4'h0;
         end
      end
   end

   // *****************************************
   // successive approximation
   // *****************************************
   // decide current bit, then trial the next one at zero
   always_comb begin
      next_trimCode = trimCode;
      next_trimPtr = {1'b0, trimPtr[7:1]};
      if (result != 8'h00) begin
         // converter reads zero for a zero or negative output
         next_trimCode = trimCode | trimPtr; // raise node, pull output down
      end else begin
         next_trimCode = trimCode & ~trimPtr; // lower node, output rises
      end
      if (next_trimPtr != 8'h00) begin
         next_trimCode = next_trimCode & ~next_trimPtr;
      end
   end

   // trim code and bit pointer; untouched outside zeroing
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         trimCode <= TRIM_CODE_INIT;
         trimPtr <= TRIM_PTR_INIT;
      end else if (ce) begin
         if (state == S_SW) begin
            trimCode <= TRIM_CODE_INIT;
            trimPtr <= TRIM_PTR_INIT;
         end else if (state == S_EVAL) begin
            trimCode <= next_trimCode;
            trimPtr <= next_trimPtr;
         end
      end
   end

   // approximation counter, reported in status
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         convCount <= 4'h0;
      end else if (ce) begin
         if (state == S_SW) begin
            convCount <= 4'h0;
         end else if (state == S_EVAL) begin
            convCount <= convCount + 4'h1;
         end
      end
   end

   // result capture; the buffers invert the result read path, writes go out as is
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         result <= 8'h00;
      end else if (ce && readLast) begin
         result <= dataStable ^ RESULT_INVERT;
      end
   end

   // switch image: zero switch closed on entry, both bits flipped at the end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         swState <= 8'h00;
      end else if (ce) begin
         if (state == S_SW) begin
            swState <= SW_ZERO_CLOSED;
         end else if (state == S_FINISH) begin
            swState <= swState ^ SW_TOGGLE;
         end
      end
   end

   // *****************************************
   // i/o bus master
   // *****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ioBus <= '0;
      end else if (ce) begin
         ioBus.wr <= 1'b0;
         ioBus.rd <= 1'b0;
         unique case (state)
            S_CFG: begin
               ioBus.addr <= PORT_CONTROL;
               ioBus.data <= CTRL_WORD_MODE0;
               ioBus.wr <= 1'b1;
            end
            S_SW: begin
               ioBus.addr <= PORT_SWITCH;
               ioBus.data <= SW_ZERO_CLOSED;
               ioBus.wr <= 1'b1;
            end
            S_TRIM: begin
               ioBus.addr <= PORT_TRIM;
               ioBus.data <= trimCode;
               ioBus.wr <= 1'b1;
            end
            S_START: begin
               ioBus.addr <= PORT_RESULT;
               ioBus.data <= START_DATA;
               ioBus.wr <= 1'b1;
            end
            S_READ: begin
               ioBus.addr <= PORT_RESULT;
               ioBus.rd <= !readLast;
            end
            S_FINISH: begin
               ioBus.addr <= PORT_SWITCH;
               ioBus.data <= swState ^ SW_TOGGLE;
               ioBus.wr <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // *****************************************
   // own registers
   // *****************************************
   // commands wait in idle; a new command wins over the take
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cmdZero <= 1'b0;
         cmdConv <= 1'b0;
      end else if (ce) begin
         if (regWr && regAddr == REG_CTRL && regWrData[CTRL_ZERO_BIT]) begin
            cmdZero <= 1'b1;
         end else if (takeZero) begin
            cmdZero <= 1'b0;
         end
         if (regWr && regAddr == REG_CTRL && regWrData[CTRL_CONV_BIT]) begin
            cmdConv <= 1'b1;
         end else if (takeConv) begin
            cmdConv <= 1'b0;
         end
      end
   end

   // sticky done flags, cleared by writing one; set wins
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         zeroDone <= 1'b0;
         convDone <= 1'b0;
      end else if (ce) begin
         if (state == S_FINISH) begin
            zeroDone <= 1'b1;
         end else if (regWr && regAddr == REG_STATUS && regWrData[STAT_ZERODONE_BIT]) begin
            zeroDone <= 1'b0;
         end
         if (readLast && !zeroing) begin
            convDone <= 1'b1;
         end else if (regWr && regAddr == REG_STATUS && regWrData[STAT_CONVDONE_BIT]) begin
            convDone <= 1'b0;
         end
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdData <= 16'h0000;
      end else if (ce) begin
         regRdData <= 16'h0000;
         if (regRd) begin
            unique case (regAddr)
               REG_CTRL: regRdData <= {14'h0000, cmdConv, cmdZero};
               REG_STATUS: regRdData <= {8'h00, convCount, zeroing, convDone,
                                         zeroDone, state != S_IDLE};
               REG_TRIM: regRdData <= {8'h00, trimCode};
               REG_RESULT: regRdData <= {8'h00, result};
               REG_SWITCH: regRdData <= {8'h00, swState};
               REG_HANDLER: regRdData <= HANDLER_ENTRY;
               default: regRdData <= 16'h0000;
            endcase
         end
      end
   end

   // *****************************************
   // assertions
   // *****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_trimWrite;
      ioBus.wr && ioBus.addr == PORT_TRIM;
   endsequence

   sequence s_startWrite;
      ioBus.wr && ioBus.addr == PORT_RESULT;
   endsequence

   a_cfg_word: assert property (ce && state == S_CFG |=> ioBus.wr &&
      ioBus.addr == PORT_CONTROL && ioBus.data == CTRL_WORD_MODE0)
      else $error("control word not written in basic mode");

   a_start_follows: assert property (s_trimWrite ##0 ce |=> ##[0:8] s_startWrite)
      else $error("no conversion start after trim update");

   a_zero_sw_held: assert property (zeroing && state inside {S_TRIM, S_WAIT, S_EVAL}
      |-> swState == SW_ZERO_CLOSED)
      else $error("zero switch not closed during zeroing");

   a_finish_sw: assert property (ce && state == S_FINISH |=> ioBus.wr &&
      ioBus.addr == PORT_SWITCH && ioBus.data == (SW_ZERO_CLOSED ^ SW_TOGGLE))
      else $error("switches not swapped at end of zeroing");

   a_eight_approx: assert property ($rose(zeroDone) |-> convCount == APPROX_COUNT)
      else $error("zeroing did not take eight approximations");

   a_clear_on_zero: assert property (ce && state == S_EVAL && result == 8'h00
      |=> (trimCode & $past(trimPtr)) == 8'h00)
      else $error("trim bit not cleared on zero result");

   a_set_on_nonzero: assert property (ce && state == S_EVAL && result != 8'h00
      |=> (trimCode & $past(trimPtr)) == $past(trimPtr))
      else $error("trim bit not set on nonzero result");

   a_trim_hold: assert property (!zeroing && state != S_IDLE |=> $stable(trimCode))
      else $error("trim code moved during a normal conversion");

   a_read_port: assert property ($rose(ioBus.rd) |-> ioBus.addr == PORT_RESULT ##1
      ioBus.rd [*2])
      else $error("result read strobe wrong or too short");

endmodule // azc_ctrl

`default_nettype wire

// ==== rtl/azc_pkg.sv ====
// shared constants and types for the auto-zero trim controller
package azc_pkg;

   // *****************************************
   // far-side port adapter i/o map
   // *****************************************
   localparam logic [7:0] PORT_RESULT = 8'hE4; // result input port, write also starts a conversion
   localparam logic [7:0] PORT_TRIM = 8'hE5;
   localparam logic [7:0] PORT_SWITCH = 8'hE6;
   localparam logic [7:0] PORT_CONTROL = 8'hE7;
   localparam logic [7:0] CTRL_WORD_MODE0 = 8'h90; // basic mode, A in, B and C out
   localparam logic [7:0] START_DATA = 8'h00;

   // *****************************************
   // trim and switch codes
   // *****************************************
   localparam logic [7:0] TRIM_PTR_INIT = 8'h80;
   localparam logic [7:0] TRIM_CODE_INIT = 8'h7F;
   localparam logic [7:0] SW_ZERO_CLOSED = 8'h01; // zero_switch closed, signal_switch open
   localparam logic [7:0] SW_TOGGLE = 8'h03;
   localparam logic [7:0] RESULT_INVERT = 8'hFF;
   localparam logic [3:0] APPROX_COUNT = 4'h8;
   localparam logic [15:0] HANDLER_ENTRY = 16'h3C3D;

   // *****************************************
   // own register map (word index on the plain port)
   // *****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_TRIM = 4'h2;
   localparam logic [3:0] REG_RESULT = 4'h3;
   localparam logic [3:0] REG_SWITCH = 4'h4;
   localparam logic [3:0] REG_HANDLER = 4'h5;
   localparam int CTRL_ZERO_BIT = 0;
   localparam int CTRL_CONV_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ZERODONE_BIT = 1;
   localparam int STAT_CONVDONE_BIT = 2;
   localparam int STAT_ZEROING_BIT = 3;

   // *****************************************
   // timing
   // *****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int RD_STROBE_NS = 100; // least read strobe width; the controller holds ioBus.rd high for three cycles, 75 ns
   localparam int RD_CYCLES_INT = (RD_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RD_CYCLES = 4'(RD_CYCLES_INT);

   // *****************************************
   // types
   // *****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic wr;
      logic rd;
   } azc_iobus_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_CFG = 4'h1,
      S_SW = 4'h2,
      S_TRIM = 4'h3,
      S_START = 4'h4,
      S_WAIT = 4'h5,
      S_READ = 4'h6,
      S_EVAL = 4'h7,
      S_FINISH = 4'h8
   } azc_state_t;

endpackage

// ==== rtl/azc_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module azc_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] INIT = '0
) (
   // clocking
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // pin side
   input wire logic [W-1:0] pinIn,
   // clean side
   output logic [W-1:0] stable
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // shift chain; s1 feeds s2 only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
      end else if (ce) begin
         s1 <= pinIn;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stable <= INIT;
      end else if (ce && (s2 == s3)) begin
         stable <= s3;
      end
   end
endmodule // azc_sync

`default_nettype wire

// ==== bench/azc_adapter_model.sv ====
// far-side model: port adapter, converter and preamp with trim ladder
`timescale 1ns/100ps
`default_nettype none

module azc_adapter_model
   import azc_pkg::*;
(
   // clocking
   input wire logic clk_sys,
   // controller side
   input wire azc_iobus_t ioBus,
   output logic [7:0] ioRdData,
   output logic intrReq_n
);
   // ***********************************
   // settings the bench adjusts per run
   // ***********************************
   int offset = 0;
   int sig = 0;
   int convDelay = 20;
   // images of what the controller wrote
   logic [7:0] ctrlWord = 8'h00;
   logic [7:0] swVal = 8'h00;
   logic [7:0] trimVal = 8'h00;
   logic [7:0] trimLog[$];
   logic [7:0] swLog[$];
   int badCount = 0;
   int busyCnt = 0;
   int v;

   // no reset on the real part, so power up idle
   initial begin
      ioRdData = 8'hFF;
      intrReq_n = 1'b1;
   end

   // port decode and conversion timing
   always @(posedge clk_sys) begin
      if (busyCnt > 0) busyCnt <= busyCnt - 1;
      if (ioBus.wr) begin
         case (ioBus.addr)
            8'hE7: ctrlWord <= ioBus.data;
            8'hE6: swVal <= ioBus.data;
            8'hE5: begin
               trimVal <= ioBus.data;
               trimLog.push_back(ioBus.data);
            end
            8'hE4: begin
               busyCnt <= convDelay;
               intrReq_n <= 1'b1;
               swLog.push_back(swVal);
            end
            default: badCount <= badCount + 1;
         endcase
      end
      // reading the result port drops the request
      if (ioBus.rd && ioBus.addr == 8'hE4) intrReq_n <= 1'b1;
      if (busyCnt == 1) begin
         // open input (no switch closed) picks up a stray level
         v = (swVal[1] ? sig : (swVal[0] ? 0 : 37)) + offset - int'(trimVal);
         // negative input converts to all zero
         ioRdData <= ~8'(v <= 0 ? 0 : (v > 255 ? 255 : v));
         intrReq_n <= 1'b0;
      end
   end
endmodule // azc_adapter_model

`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the auto-zero trim controller
`timescale 1ns/100ps
`default_nettype none

module tb
   import azc_pkg::*;
;
   // ***********************************
   // clock, reset and wiring
   // ***********************************
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdData;
   azc_iobus_t ioBus;
   logic [7:0] ioRdData;
   logic intrReq_n;
   int failCount = 0;
   int checked = 0;
   int offs = 0;
   logic [7:0] lastTrial = 8'h00;
   logic [15:0] rd;

   always #12.5 clk_sys = ~clk_sys;

   azc_ctrl uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData),
      .ioBus(ioBus), .ioRdData(ioRdData), .intrReq_n(intrReq_n)
   );

   azc_adapter_model model (
      .clk_sys(clk_sys), .ioBus(ioBus), .ioRdData(ioRdData), .intrReq_n(intrReq_n)
   );

   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         failCount++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // register port cycles, one strobe cycle each
   task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask

   task automatic regRead(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 rd = regRdData;
   endtask

   // bounded poll, a hang ends the run
   task automatic waitStatus(input int b);
      for (int i = 0; i < 3000; i++) begin
         regRead(REG_STATUS);
         if (rd[b] === 1'b1) return;
      end
      failCount++;
      $display("unexpected at %0t: status bit %0d never set", $time, b);
      end_of_test();
   endtask

   task automatic test_reset();
      regRead(REG_TRIM);
      check(rd, 16'h007F, "trim after reset");
      regRead(REG_SWITCH);
      check(rd, 16'h0000, "switch after reset");
      regRead(REG_HANDLER);
      check(rd, 16'h3C3D, "handler entry");
      regWrite(4'hA, 16'hFFFF);
      regRead(4'hA);
      check(rd, 16'h0000, "unmapped index");
      check(16'(model.trimLog.size()), 16'h0000, "port quiet before command");
   endtask

   task automatic test_zeroing(input int o, input int dly);
      int tb0;
      int sb0;
      logic [7:0] prefix;
      logic [7:0] trial;
      tb0 = model.trimLog.size();
      sb0 = model.swLog.size();
      prefix = 8'h00;
      trial = 8'h00;
      offs = o;
      model.offset = o;
      model.convDelay = dly;
      // signal must not leak in while the zero switch is closed
      model.sig = 77;
      regWrite(REG_STATUS, 16'h0006);
      regWrite(REG_CTRL, 16'h0001);
      waitStatus(STAT_ZERODONE_BIT);
      for (int k = 7; k >= 0; k--) begin
         trial = prefix | 8'((1 << k) - 1);
         check({8'h00, model.trimLog[tb0 + 7 - k]}, {8'h00, trial}, "trial");
         check({8'h00, model.swLog[sb0 + 7 - k]}, 16'h0001, "zero switch");
         if (o > int'(trial)) prefix = prefix | 8'(1 << k);
      end
      lastTrial = trial;
      check(16'(model.trimLog.size() - tb0), 16'h0008, "trim writes");
      check(16'(model.swLog.size() - sb0), 16'h0008, "conversions");
      check({8'h00, model.swVal}, 16'h0002, "switches after zeroing");
      check({8'h00, model.ctrlWord}, 16'h0090, "adapter mode");
      check(16'(model.badCount), 16'h0000, "stray port");
      regRead(REG_TRIM);
      check(rd, {8'h00, prefix}, "final trim code");
      regWrite(REG_STATUS, 16'h0002);
      regRead(REG_STATUS);
      check({15'h0000, rd[STAT_ZERODONE_BIT]}, 16'h0000, "done flag cleared");
   endtask

   task automatic test_normal(input int s);
      int n0;
      int v;
      n0 = model.trimLog.size();
      model.sig = s;
      v = s + offs - int'(lastTrial);
      regWrite(REG_STATUS, 16'h0006);
      regWrite(REG_CTRL, 16'h0002);
      waitStatus(STAT_CONVDONE_BIT);
      regRead(REG_RESULT);
      check(rd, 16'(v <= 0 ? 0 : (v > 255 ? 255 : v)), "result");
      check(16'(model.trimLog.size() - n0), 16'h0000, "trim held");
      check({8'h00, model.swLog[model.swLog.size() - 1]}, 16'h0002, "signal switch");
   endtask

   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      // reset held for two edges; the request synchroniser resets to its idle pin level, the data one to zero
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      test_reset();
      test_zeroing(8'h5A, 20);
      test_normal(30);
      test_normal(-100);
      test_normal(400);
      test_zeroing(8'h00, 200);
      test_normal(8'h10);
      test_zeroing(8'hFF, 5);
      test_normal(0);
      test_zeroing(8'h81, 20);
      test_normal(8'h40);
      end_of_test();
   end
endmodule // tb

`default_nettype wire
